// File: rssm_alu.sv
`timescale 1ns/1ps
`default_nettype none

package rssm_pkg;
    localparam int          DATA_W      = 8;
    localparam int          NIB_W       = 4;
    localparam int          FILE_ADDR_W = 6;
    localparam int          SPR_ADDR_W  = 4;
    localparam int          FILE_DEPTH  = 64;
    localparam int          SPR_DEPTH   = 16;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  MEM_RESET   = 8'h00;
    localparam logic        DEST_ACC    = 1'b0;
    localparam logic        DEST_FILE   = 1'b1;

    typedef enum logic [2:0] {
        RSSM_OP_LD_FLAGS = 3'b000,
        RSSM_OP_ROTATE   = 3'b001,
        RSSM_OP_SBC_REG  = 3'b010,
        RSSM_OP_SBC_IMM  = 3'b011,
        RSSM_OP_SPR_READ = 3'b100,
        RSSM_OP_LD_ACC   = 3'b101,
        RSSM_OP_LD_FILE  = 3'b110,
        RSSM_OP_LD_SPR   = 3'b111
    } rssm_op_t;

    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } rssm_flags_t;

    localparam rssm_flags_t FLAGS_RESET = 3'h0;

    typedef struct packed {
        rssm_op_t                 op;
        logic                     dest;
        logic [FILE_ADDR_W-1:0]   faddr;
        logic [SPR_ADDR_W-1:0]    saddr;
        logic [DATA_W-1:0]        imm;
    } rssm_instr_t;
endpackage : rssm_pkg

module rssm_alu (
    // Operation and operands
    input  wire rssm_pkg::rssm_op_t     op,
    input  wire logic [7:0]             operand,
    input  wire logic [7:0]             acc,
    input  wire rssm_pkg::rssm_flags_t  flags_in,
    // Results
    output logic [7:0]                  result,
    output rssm_pkg::rssm_flags_t       flags_out
);
    import rssm_pkg::*;

    logic [DATA_W:0] sum;
    logic [NIB_W:0]  low_sum;

    always_comb begin
        sum       = {1'b0, operand} + {1'b0, ~acc} + {8'h00, flags_in.carry};
        low_sum   = {1'b0, operand[NIB_W-1:0]} + {1'b0, ~acc[NIB_W-1:0]}
                    + {4'h0, flags_in.carry};
        result    = acc;
        flags_out = flags_in;
        unique case (op)
            RSSM_OP_ROTATE: begin
                result          = {flags_in.carry, operand[DATA_W-1:1]};
                flags_out.carry = operand[0];
            end
            RSSM_OP_SBC_REG, RSSM_OP_SBC_IMM: begin
                result                     = sum[DATA_W-1:0];
                flags_out.carry            = sum[DATA_W];
                flags_out.digit_carry_flag = low_sum[NIB_W];
                flags_out.zero             = (sum[DATA_W-1:0] == 8'h00);
            end
            RSSM_OP_SPR_READ, RSSM_OP_LD_ACC: begin
                result = operand;
            end
            RSSM_OP_LD_FLAGS: begin
                flags_out = operand[2:0];
            end
            RSSM_OP_LD_FILE, RSSM_OP_LD_SPR: begin
                result = acc;
            end
        endcase
    end
endmodule : rssm_alu

`default_nettype wire

// File: rssm_core.sv
// Operation
// - Rotate right through carry, only carry changes
// - Destination bit 0 writes accumulator only
// - Destination bit 1 writes file register
// - Register plus inverted accumulator plus carry
// - Immediate subtract-with-borrow always to accumulator
// - Special-page register copied, left unchanged
// - Zero flag reflects all-zero subtract result
`timescale 1ns/1ps
`default_nettype none

module rssm_core (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Instruction issue
    input  wire logic                  instr_valid,
    input  wire rssm_pkg::rssm_instr_t instr,
    // Observation of the file registers
    input  wire logic [5:0]            obs_addr,
    output logic [7:0]                 obs_data,
    // Architectural state
    output logic [7:0]                 work_accumulator,
    output rssm_pkg::rssm_flags_t      flags,
    output logic [7:0]                 result,
    output logic                       done
);
    import rssm_pkg::*;

    logic [DATA_W-1:0] file_mem [FILE_DEPTH];
    logic [DATA_W-1:0] spr_mem  [SPR_DEPTH];
    logic [DATA_W-1:0] acc_reg;
    logic [DATA_W-1:0] acc_next;
    rssm_flags_t       flags_reg;
    rssm_flags_t       flags_next;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] alu_result;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] obs_reg;
    logic              done_reg;
    logic              reg_form;
    logic              wr_acc;
    logic              wr_file;
    logic              wr_spr;

    rssm_alu u_alu (
        .op        (instr.op),
        .operand   (operand),
        .acc       (acc_reg),
        .flags_in  (flags_reg),
        .result    (alu_result),
        .flags_out (flags_next)
    );

    always_comb begin
        unique case (instr.op)
            RSSM_OP_SBC_IMM, RSSM_OP_LD_ACC, RSSM_OP_LD_FLAGS: operand = instr.imm;
            RSSM_OP_SPR_READ: operand = spr_mem[instr.saddr];
            default:          operand = file_mem[instr.faddr];
        endcase
    end

    // Write-back steering
    assign reg_form = (instr.op == RSSM_OP_ROTATE) || (instr.op == RSSM_OP_SBC_REG);
    assign wr_acc   = instr_valid && ((reg_form && instr.dest == DEST_ACC)
                      || instr.op == RSSM_OP_SBC_IMM
                      || instr.op == RSSM_OP_SPR_READ
                      || instr.op == RSSM_OP_LD_ACC);
    assign wr_file  = instr_valid && ((reg_form && instr.dest == DEST_FILE)
                      || instr.op == RSSM_OP_LD_FILE);
    assign wr_spr   = instr_valid && instr.op == RSSM_OP_LD_SPR;
    assign acc_next = wr_acc ? alu_result : acc_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_reg <= ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= FLAGS_RESET;
        end else if (instr_valid) begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= MEM_RESET;
            end
        end else if (wr_file) begin
            file_mem[instr.faddr] <= alu_result;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < SPR_DEPTH; i++) begin
                spr_mem[i] <= MEM_RESET;
            end
        end else if (wr_spr) begin
            spr_mem[instr.saddr] <= alu_result;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_reg <= MEM_RESET;
            done_reg   <= 1'b0;
            obs_reg    <= MEM_RESET;
        end else begin
            if (instr_valid) begin
                result_reg <= alu_result;
            end
            done_reg <= instr_valid;
            obs_reg  <= file_mem[obs_addr];
        end
    end

    assign work_accumulator = acc_reg;
    assign flags            = flags_reg;
    assign result           = result_reg;
    assign done             = done_reg;
    assign obs_data         = obs_reg;

    // Checking helpers: operands captured at issue
    rssm_instr_t       instr_q;
    logic [DATA_W-1:0] opnd_q;
    logic [DATA_W-1:0] acc_q;
    rssm_flags_t       flags_q;
    logic [DATA_W-1:0] fval_q;
    logic [NIB_W:0]    nib_chk;
    logic [DATA_W-1:0] diff_chk;

    always_ff @(posedge clk) begin
        if (instr_valid) begin
            instr_q <= instr;
            opnd_q  <= operand;
            acc_q   <= acc_reg;
            flags_q <= flags_reg;
            fval_q  <= file_mem[instr.faddr];
        end
    end

    // Reference arithmetic rebuilt from the captured operands, not from the ALU
    assign nib_chk  = {1'b0, opnd_q[NIB_W-1:0]} + {1'b0, ~acc_q[NIB_W-1:0]}
                      + {4'h0, flags_q.carry};
    assign diff_chk = opnd_q + ~acc_q + {7'h00, flags_q.carry};

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_issue(rssm_op_t o);
        instr_valid && instr.op == o;
    endsequence

    sequence s_reg_issue(rssm_op_t o, logic d);
        instr_valid && instr.op == o && instr.dest == d;
    endsequence

    a_rotate_value: assert property (s_issue(RSSM_OP_ROTATE) |=>
        result == {flags_q.carry, opnd_q[7:1]} && flags.carry == opnd_q[0]
        && flags.zero == flags_q.zero
        && flags.digit_carry_flag == flags_q.digit_carry_flag)
        else $error("rotate result or flags wrong");

    a_dest_acc_only: assert property (
        (s_reg_issue(RSSM_OP_ROTATE, DEST_ACC) or s_reg_issue(RSSM_OP_SBC_REG, DEST_ACC))
        |=> work_accumulator == result && file_mem[instr_q.faddr] == opnd_q)
        else $error("destination 0 did not go to accumulator only");

    a_dest_file_only: assert property (
        (s_reg_issue(RSSM_OP_ROTATE, DEST_FILE) or s_reg_issue(RSSM_OP_SBC_REG, DEST_FILE))
        |=> file_mem[instr_q.faddr] == result && work_accumulator == acc_q)
        else $error("destination 1 did not go to file register only");

    a_sbc_reg_sum: assert property (s_issue(RSSM_OP_SBC_REG) |=>
        {flags.carry, result} == {1'b0, opnd_q} + {1'b0, ~acc_q} + {8'h00, flags_q.carry})
        else $error("register subtract-with-borrow wrong");

    a_sbc_imm_acc: assert property (s_issue(RSSM_OP_SBC_IMM) |=>
        {flags.carry, work_accumulator} ==
        {1'b0, instr_q.imm} + {1'b0, ~acc_q} + {8'h00, flags_q.carry})
        else $error("immediate subtract-with-borrow wrong");

    a_spr_copy: assert property (s_issue(RSSM_OP_SPR_READ) |=>
        work_accumulator == spr_mem[instr_q.saddr] && work_accumulator == opnd_q
        && flags == flags_q)
        else $error("special-page read wrong");

    a_zero_tracks: assert property (
        (s_issue(RSSM_OP_SBC_REG) or s_issue(RSSM_OP_SBC_IMM))
        |=> flags.zero == (result == 8'h00))
        else $error("zero flag does not match result");

    a_zero_direct: assert property (
        (s_issue(RSSM_OP_SBC_REG) or s_issue(RSSM_OP_SBC_IMM))
        |=> flags.zero == (diff_chk == 8'h00))
        else $error("zero flag does not match the difference");

    a_dc_flag: assert property (
        (s_issue(RSSM_OP_SBC_REG) or s_issue(RSSM_OP_SBC_IMM))
        |=> flags.digit_carry_flag == nib_chk[NIB_W])
        else $error("digit carry flag wrong");

    a_imm_no_file: assert property (s_issue(RSSM_OP_SBC_IMM) |=>
        file_mem[instr_q.faddr] == fval_q)
        else $error("immediate subtract-with-borrow touched a file register");

    a_spr_kept: assert property (s_issue(RSSM_OP_SPR_READ) |=>
        spr_mem[instr_q.saddr] == opnd_q && file_mem[instr_q.faddr] == fval_q)
        else $error("special-page read changed a register");

    // Back-to-back issue keeps done high, so only the next cycle is checked
    a_single_cycle: assert property (instr_valid |=> done)
        else $error("instruction did not complete in one cycle");

    a_idle_hold: assert property (!instr_valid |=> !done && $stable(work_accumulator)
        && $stable(flags))
        else $error("state changed without an instruction");

endmodule : rssm_core

`default_nettype wire

// File: rssm_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rssm_core_tb_top;
    import rssm_pkg::*;
    typedef struct packed {
        logic [7:0]  res;
        logic [7:0]  acc;
        rssm_flags_t fl;
        logic        chk_res;
        logic        chk_fl;
    } rssm_exp_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        instr_valid = 1'b0;
    rssm_instr_t instr = '0;
    logic [5:0]  obs_addr = 6'h00;
    logic [7:0]  obs_data, work_accumulator, result;
    rssm_flags_t flags;
    logic        done;
    rssm_exp_t   exp_q[$];
    rssm_exp_t   me;
    rssm_op_t    op;
    logic [7:0]  m_file[64];
    logic [7:0]  m_spr[16];
    logic [7:0]  m_acc = 8'h00;
    rssm_flags_t m_fl = FLAGS_RESET;
    int          errors = 0;
    int          checks = 0;
    int          seed = 70;
    always #4 clk = ~clk;
    rssm_core DUT (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .obs_addr(obs_addr), .obs_data(obs_data), .work_accumulator(work_accumulator),
        .flags(flags), .result(result), .done(done));
    task automatic fail(input string msg);
        errors++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask : fail
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string w);
        checks++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", w, got, exp));
    endtask : cmp_byte
    task automatic cmp_flags(input rssm_flags_t got, input rssm_flags_t exp);
        checks++;
        if (got !== exp) fail($sformatf("flags got %b exp %b", got, exp));
    endtask : cmp_flags
    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // Drive one instruction and note its expected outcome in the model
    task automatic issue(input rssm_op_t o, input logic d, input logic [5:0] fa,
                         input logic [3:0] sa, input logic [7:0] im);
        rssm_exp_t  e;
        logic [7:0] v;
        logic [8:0] s;
        logic [4:0] lo;
        @(negedge clk);
        instr_valid = 1'b1;
        instr = '{o, d, fa, sa, im};
        v = (o == RSSM_OP_SBC_IMM) ? im : m_file[fa];
        s = {1'b0, v} + {1'b0, ~m_acc} + 9'(m_fl.carry);
        lo = {1'b0, v[3:0]} + {1'b0, ~m_acc[3:0]} + 5'(m_fl.carry);
        e = '{8'h00, m_acc, m_fl, 1'b1, 1'b1};
        case (o)
            RSSM_OP_ROTATE: begin
                e.res = {m_fl.carry, v[7:1]};
                e.fl.carry = v[0];
            end
            RSSM_OP_SBC_REG, RSSM_OP_SBC_IMM: begin
                e.res = s[7:0];
                e.fl = '{s[7:0] == 8'h00, lo[4], s[8]};
            end
            RSSM_OP_SPR_READ: begin
                e.res = m_spr[sa];
                e.acc = m_spr[sa];
            end
            RSSM_OP_LD_FLAGS: begin
                e.fl = im[2:0];
                e.chk_res = 1'b0;
            end
            default: begin
                e.chk_res = 1'b0;
                e.chk_fl = 1'b0;
                if (o == RSSM_OP_LD_ACC) e.acc = im;
                else if (o == RSSM_OP_LD_FILE) m_file[fa] = m_acc;
                else m_spr[sa] = m_acc;
            end
        endcase
        if (o == RSSM_OP_ROTATE || o == RSSM_OP_SBC_REG) begin
            if (d) m_file[fa] = e.res;
            else e.acc = e.res;
        end
        if (o == RSSM_OP_SBC_IMM) e.acc = e.res;
        m_acc = e.acc;
        m_fl = e.fl;
        exp_q.push_back(e);
    endtask : issue
    task automatic idle;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask : idle
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("unexpected done");
            end else begin
                me = exp_q.pop_front();
                if (me.chk_res) cmp_byte(result, me.res, "result");
                cmp_byte(work_accumulator, me.acc, "acc");
                if (me.chk_fl) cmp_flags(flags, me.fl);
            end
        end
    end
    initial begin
        for (int i = 0; i < 64; i++) m_file[i] = MEM_RESET;
        for (int i = 0; i < 16; i++) m_spr[i] = MEM_RESET;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        cmp_byte(work_accumulator, ACC_RESET, "reset acc");
        cmp_flags(flags, FLAGS_RESET);
        $display("test reset ended");
        issue(RSSM_OP_LD_ACC, 1'b0, 6'h01, 4'h0, 8'hA5);
        issue(RSSM_OP_LD_FILE, 1'b0, 6'h01, 4'h0, 8'h00);
        issue(RSSM_OP_LD_FLAGS, 1'b0, 6'h00, 4'h0, 8'h00);
        issue(RSSM_OP_ROTATE, 1'b1, 6'h01, 4'h0, 8'h00);
        for (int k = 0; k < 8; k++) begin
            issue(RSSM_OP_LD_ACC, 1'b0, 6'h02, 4'h0, k[1] ? 8'h05 : 8'h06);
            issue(RSSM_OP_LD_FILE, 1'b0, 6'h02, 4'h0, 8'h00);
            issue(RSSM_OP_LD_ACC, 1'b0, 6'h02, 4'h0, k[1] ? 8'h06 : 8'h05);
            issue(RSSM_OP_LD_FLAGS, 1'b0, 6'h00, 4'h0, {7'h00, k[0]});
            issue(k[2] ? RSSM_OP_SBC_IMM : RSSM_OP_SBC_REG, 1'b1, 6'h02, 4'h0,
                  k[1] ? 8'h05 : 8'h06);
        end
        issue(RSSM_OP_LD_ACC, 1'b0, 6'h00, 4'h7, 8'h55);
        issue(RSSM_OP_LD_SPR, 1'b0, 6'h00, 4'h7, 8'h00);
        issue(RSSM_OP_LD_ACC, 1'b0, 6'h00, 4'h7, 8'hAA);
        issue(RSSM_OP_SPR_READ, 1'b0, 6'h00, 4'h7, 8'h00);
        issue(RSSM_OP_SPR_READ, 1'b1, 6'h00, 4'h7, 8'h00);
        idle();
        $display("test directed ended");
        for (int n = 0; n < 400; n++) begin
            op = rssm_op_t'(3'($random(seed)));
            issue(op, 1'($random(seed)), 6'($random(seed)), 4'($random(seed)), 8'($random(seed)));
            if (op inside {RSSM_OP_LD_ACC, RSSM_OP_LD_FILE, RSSM_OP_LD_SPR})
                issue(RSSM_OP_LD_FLAGS, 1'b0, 6'h00, 4'h0, 8'($random(seed)));
            if (n % 7 == 0) idle();
        end
        idle();
        $display("test random ended");
        for (int a = 0; a < 64; a++) begin
            @(negedge clk);
            obs_addr = 6'(a);
            @(negedge clk);
            cmp_byte(obs_data, m_file[a], "file");
        end
        if (exp_q.size() != 0) fail("missing done");
        $display("test file sweep ended");
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail("timeout");
        complete_run();
    end
endmodule : rssm_core_tb_top
`default_nettype wire
